//--- hw/scd_map.svh
// Register layout, reset value and decode constants for the synthesizer config block
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH
`define SCD_MODE_LSB 0
`define SCD_MODE_MSB 1
`define SCD_PWRDN_BIT 2
`define SCD_XTAL_BIT 3
`define SCD_PUMP_LSB 4
`define SCD_PUMP_MSB 8
`define SCD_MUX_LSB 9
`define SCD_MUX_MSB 12
`define SCD_POL_BIT 13
`define SCD_DBL_BIT 14
`define SCD_FDM_BIT 15
`define SCD_C3_LSB 16
`define SCD_C3_MSB 19
`define SCD_C4_LSB 20
`define SCD_C4_MSB 23
`define SCD_USED_MASK 32'h00FF_FFFF
`define SCD_RESET_WORD 32'h0000_8000
`define SCD_LOCK_COUNT 3'h5
`define SCD_C3_UNIT_PF 6'h05
`define SCD_FRAC_SHORT_MASK 22'h00_03FF
`define SCD_FRAC_LONG_MASK 22'h3F_FFFF
`endif

//--- hw/scd_pkg.sv
// Types shared by the synthesizer config block
`default_nettype none
package scd_pkg;
  typedef enum logic [4:0] {
    SCD_MODE_FULL = 5'h01,
    SCD_MODE_EXTVCO = 5'h02,
    SCD_MODE_DIVONLY = 5'h04,
    SCD_MODE_TEST = 5'h08,
    SCD_MODE_OFF = 5'h10
  } scd_mode_t;
  typedef struct packed {
    logic divider_en;
    logic pll_en;
    logic vco_en;
    logic crystal_select;
    logic detector_polarity;
    logic reference_doubler;
    logic ref_divider_bypass;
    logic [5:0] pump_current_steps;
    logic [5:0] filter_cap_three_pf;
    logic [7:0] filter_cap_four_pf;
    logic [21:0] fraction_mask;
  } scd_ctrl_t;
  typedef struct packed {
    logic feedback_pulse;
    logic reference_pulse;
    logic pfd_up;
    logic pfd_down;
    logic analog_lock;
  } scd_diag_t;
endpackage
`default_nettype wire

//--- hw/scd_config_decode.sv
// Configuration decode, lock detector and test pin multiplexer
`include "scd_map.svh"
`default_nettype none
module scd_config_decode
  import scd_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Word write from the serial port
  input wire logic cfg_wr_en,
  input wire logic [31:0] cfg_wr_data,
  output logic [31:0] misc_feature_control,
  // Lock detector inputs
  input wire logic pd_cycle,
  input wire logic offset_in_window,
  // Diagnostic sources
  input wire scd_diag_t diag,
  // Decoded controls
  output scd_ctrl_t ctrl,
  output logic powered_down,
  output logic digital_lock,
  // Test and lock pin
  output logic test_lock_output_o,
  output logic test_lock_output_oe
);
  logic [31:0] cfg_reg, cfg_next;
  logic [2:0] cnt_reg, cnt_next;
  logic lock_reg, lock_next;
  logic fb_half_reg, fb_half_next;
  logic ref_half_reg, ref_half_next;
  scd_ctrl_t ctrl_reg, ctrl_next;
  logic pd_reg, pd_next;
  logic pin_o_reg, pin_o_next, pin_oe_reg, pin_oe_next;
  scd_mode_t mode_s;
  logic [1:0] mode_f;
  logic [4:0] pump_f;
  logic [3:0] mux_f, c3_f, c4_f;

  assign mode_f = cfg_reg[`SCD_MODE_MSB:`SCD_MODE_LSB];
  assign pump_f = cfg_reg[`SCD_PUMP_MSB:`SCD_PUMP_LSB];
  assign mux_f = cfg_reg[`SCD_MUX_MSB:`SCD_MUX_LSB];
  assign c3_f = cfg_reg[`SCD_C3_MSB:`SCD_C3_LSB];
  assign c4_f = cfg_reg[`SCD_C4_MSB:`SCD_C4_LSB];

  // Stored word survives power-down; only a write or a reset changes it
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_wr_en) begin
      cfg_next = cfg_wr_data & `SCD_USED_MASK;
    end
  end

  // Lock detector, evaluated once per phase detector cycle
  always_comb begin
    cnt_next = cnt_reg;
    lock_next = lock_reg;
    if (pd_cycle) begin
      if (!offset_in_window) begin
        cnt_next = 3'h0;
        lock_next = 1'b0;
      end else if (!lock_reg) begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg + 3'h1 == `SCD_LOCK_COUNT) begin
          lock_next = 1'b1;
        end
      end
    end
  end

  // Halved diagnostics toggle on each divider pulse for even duty
  always_comb begin
    fb_half_next = fb_half_reg ^ diag.feedback_pulse;
    ref_half_next = ref_half_reg ^ diag.reference_pulse;
  end

  always_comb begin
    unique case (mode_f)
      2'h0: mode_s = SCD_MODE_FULL;
      2'h1: mode_s = SCD_MODE_EXTVCO;
      2'h2: mode_s = SCD_MODE_DIVONLY;
      2'h3: mode_s = SCD_MODE_TEST;
    endcase
    if (cfg_reg[`SCD_PWRDN_BIT]) begin
      mode_s = SCD_MODE_OFF;
    end
  end

  // Control decode
  always_comb begin
    ctrl_next = '0;
    pd_next = cfg_reg[`SCD_PWRDN_BIT];
    unique case (mode_s)
      SCD_MODE_FULL, SCD_MODE_TEST: begin
        ctrl_next.divider_en = 1'b1;
        ctrl_next.pll_en = 1'b1;
        ctrl_next.vco_en = 1'b1;
      end
      SCD_MODE_EXTVCO: begin
        ctrl_next.divider_en = 1'b1;
        ctrl_next.pll_en = 1'b1;
      end
      SCD_MODE_DIVONLY: begin
        ctrl_next.divider_en = 1'b1;
      end
      SCD_MODE_OFF: begin
        ctrl_next.divider_en = 1'b0;
      end
    endcase
    ctrl_next.crystal_select = cfg_reg[`SCD_XTAL_BIT];
    ctrl_next.detector_polarity = cfg_reg[`SCD_POL_BIT];
    ctrl_next.reference_doubler = cfg_reg[`SCD_DBL_BIT];
    ctrl_next.ref_divider_bypass = cfg_reg[`SCD_DBL_BIT];
    ctrl_next.pump_current_steps = {1'b0, pump_f} + 6'h01;
    ctrl_next.filter_cap_three_pf = {5'h00, c3_f[0]}
      + 6'(c3_f[3:1] * `SCD_C3_UNIT_PF);
    ctrl_next.filter_cap_four_pf = (c4_f[0] ? 8'h05 : 8'h00)
      + (c4_f[1] ? 8'h14 : 8'h00)
      + (c4_f[2] ? 8'h28 : 8'h00)
      + (c4_f[3] ? 8'h64 : 8'h00);
    ctrl_next.fraction_mask = cfg_reg[`SCD_FDM_BIT] ?
      `SCD_FRAC_LONG_MASK : `SCD_FRAC_SHORT_MASK;
  end

  // Test and lock pin
  always_comb begin
    pin_o_next = 1'b0;
    pin_oe_next = 1'b1;
    unique case (mux_f)
      4'h0: pin_oe_next = 1'b0;
      4'h1: pin_o_next = 1'b1;
      4'h2: pin_o_next = 1'b0;
      4'h3: pin_o_next = lock_reg;
      4'h4: pin_o_next = !lock_reg;
      4'h5: pin_oe_next = !lock_reg;
      4'h6: pin_oe_next = !diag.analog_lock;
      4'h7: pin_o_next = diag.analog_lock;
      4'h8: pin_o_next = diag.feedback_pulse;
      4'h9: pin_o_next = fb_half_reg;
      4'hA: pin_o_next = diag.reference_pulse;
      4'hB: pin_o_next = ref_half_reg;
      4'hC: pin_o_next = diag.pfd_up;
      4'hD: pin_o_next = diag.pfd_down;
      // Reserved codes float the pin rather than guess a function
      4'hE, 4'hF: pin_oe_next = 1'b0;
    endcase
    if (cfg_reg[`SCD_PWRDN_BIT]) begin
      pin_oe_next = 1'b0;
      pin_o_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_reg <= `SCD_RESET_WORD;
      cnt_reg <= 3'h0;
      lock_reg <= 1'b0;
      fb_half_reg <= 1'b0;
      ref_half_reg <= 1'b0;
      ctrl_reg <= '0;
      pd_reg <= 1'b0;
      pin_o_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else if (ce) begin
      cfg_reg <= cfg_next;
      cnt_reg <= cnt_next;
      lock_reg <= lock_next;
      fb_half_reg <= fb_half_next;
      ref_half_reg <= ref_half_next;
      ctrl_reg <= ctrl_next;
      pd_reg <= pd_next;
      pin_o_reg <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign misc_feature_control = cfg_reg;
  assign ctrl = ctrl_reg;
  assign powered_down = pd_reg;
  assign digital_lock = lock_reg;
  assign test_lock_output_o = pin_o_reg;
  assign test_lock_output_oe = pin_oe_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_mode_extvco;
    ce && !cfg_reg[`SCD_PWRDN_BIT] && mode_f == 2'h1 |=>
      ctrl.pll_en && ctrl.divider_en && !ctrl.vco_en;
  endproperty
  a_mode_extvco: assert property (p_mode_extvco) else $error("mode 1 decode wrong");

  property p_mode_divonly;
    ce && !cfg_reg[`SCD_PWRDN_BIT] && mode_f == 2'h2 |=>
      ctrl.divider_en && !ctrl.pll_en && !ctrl.vco_en;
  endproperty
  a_mode_divonly: assert property (p_mode_divonly) else $error("mode 2 decode wrong");

  property p_powerdown;
    ce && cfg_reg[`SCD_PWRDN_BIT] |=> !ctrl.divider_en && !ctrl.vco_en && powered_down
      && !test_lock_output_oe;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("power-down left a function on");

  property p_retain;
    !cfg_wr_en |=> $stable(misc_feature_control);
  endproperty
  a_retain: assert property (p_retain) else $error("stored word changed without write");

  property p_pump;
    ce |=> ctrl.pump_current_steps == {1'b0, $past(pump_f)} + 6'h01;
  endproperty
  a_pump: assert property (p_pump) else $error("pump steps not code plus one");

  property p_c4_top;
    ce && c4_f == 4'hF |=> ctrl.filter_cap_four_pf == 8'hA5;
  endproperty
  a_c4_top: assert property (p_c4_top) else $error("C4 code 15 not 165 pF");

  property p_c3_top;
    ce && c3_f == 4'hF |=> ctrl.filter_cap_three_pf == 6'h24;
  endproperty
  a_c3_top: assert property (p_c3_top) else $error("C3 code 15 not 36 pF");

  property p_lock_after_five;
    ce && pd_cycle && !offset_in_window ##1 (ce && pd_cycle && offset_in_window)[*5]
      |=> digital_lock;
  endproperty
  a_lock_after_five: assert property (p_lock_after_five) else $error("no lock after 5");

  property p_unlock;
    ce && pd_cycle && !offset_in_window |=> !digital_lock;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock held past window");

  property p_ld_pushpull;
    ce && mux_f == 4'h3 && !cfg_reg[`SCD_PWRDN_BIT] |=>
      test_lock_output_oe && test_lock_output_o == $past(lock_reg);
  endproperty
  a_ld_pushpull: assert property (p_ld_pushpull) else $error("code 3 pin wrong");

  property p_hiz;
    ce && mux_f == 4'h0 |=> !test_lock_output_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("code 0 pin driven");

  property p_fraction;
    ce && !cfg_reg[`SCD_FDM_BIT] |=> ctrl.fraction_mask == `SCD_FRAC_SHORT_MASK;
  endproperty
  a_fraction: assert property (p_fraction) else $error("short fraction mask wrong");

  property p_doubler;
    ce |=> ctrl.ref_divider_bypass == $past(cfg_reg[`SCD_DBL_BIT]);
  endproperty
  a_doubler: assert property (p_doubler) else $error("doubler bypass wrong");

  c_lock: cover property (ce && pd_cycle ##1 digital_lock);
  c_half: cover property (mux_f == 4'h9 && test_lock_output_o ##[1:20] !test_lock_output_o);
  c_pwrdn: cover property (powered_down ##1 !powered_down);
endmodule
`default_nettype wire

//--- testbench/scd_host_model.sv
// Host controller model that writes configuration words
`default_nettype none
module scd_host_model (
  // Clock
  input wire logic ref_clk,
  // Word write toward the block
  output logic cfg_wr_en,
  output logic [31:0] cfg_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle word: push-pull lock detect on the test pin
  localparam logic [31:0] IDLE_WORD = 32'h0000_8600;
  initial begin
    cfg_wr_en = 1'b0;
    cfg_wr_data = IDLE_WORD;
  end
  // Wide fraction may stay set, this host never keys frequency
  task automatic put(input logic [31:0] w, input logic slow);
    @(negedge ref_clk);
    if (slow) begin
      @(negedge ref_clk);
    end
    cfg_wr_en = 1'b1;
    cfg_wr_data = w;
    @(negedge ref_clk);
    cfg_wr_en = 1'b0;
    // Released data must not look valid
    cfg_wr_data = ~w;
  endtask
endmodule
`default_nettype wire

//--- testbench/scd_config_decode_tb.sv
// Self-checking bench for the synthesizer config decode
`default_nettype none
module scd_config_decode_tb;
  import scd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic pd_cycle = 1'b0;
  logic offset_in_window = 1'b0;
  scd_diag_t diag = '0;
  logic cfg_wr_en;
  logic [31:0] cfg_wr_data;
  logic [31:0] misc_feature_control;
  scd_ctrl_t ctrl;
  logic powered_down, digital_lock, pin_o, pin_oe;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int c4_pf[16] = '{0, 5, 20, 25, 40, 45, 60, 65, 100, 105, 120, 125, 140, 145, 160, 165};
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  scd_host_model u_host (.ref_clk(ref_clk), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data));
  scd_config_decode u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_data(cfg_wr_data), .misc_feature_control(misc_feature_control), .pd_cycle(pd_cycle),
    .offset_in_window(offset_in_window), .diag(diag), .ctrl(ctrl), .powered_down(powered_down),
    .digital_lock(digital_lock), .test_lock_output_o(pin_o), .test_lock_output_oe(pin_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pin level only matters while driven
  task automatic chk_pin(input logic o, input logic oe);
    n_compared++;
    if (pin_oe !== oe || (oe && pin_o !== o)) begin
      errors++;
      $display("ERROR at %0t: pin oe/o %b/%b", $time, pin_oe, pin_o);
    end
  endtask
  function automatic logic [31:0] mk(input logic [1:0] md, input logic pd, input logic [4:0] pu,
    input logic [3:0] mx, input logic [3:0] c3, input logic [3:0] c4, input logic [3:0] b);
    return {8'h00, c4, c3, b[3:1], mx, pu, b[0], pd, md};
  endfunction
  task automatic wr(input logic [31:0] d);
    u_host.put(d, d[0]);
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic test_pin_select(input logic [3:0] m);
    wr(mk(2'h0, 1'b0, 5'h00, m, 4'h0, 4'h0, 4'h8));
  endtask
  task automatic pulses(input int n, input logic inw);
    repeat (n) begin
      @(negedge ref_clk);
      pd_cycle = 1'b1;
      offset_in_window = inw;
    end
    @(negedge ref_clk);
    pd_cycle = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic diag_hit(input logic [4:0] m, input int hold);
    diag = m;
    repeat (hold) @(negedge ref_clk);
    diag = '0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic t_reset;
    repeat (2) @(negedge ref_clk);
    chk(misc_feature_control, 32'h0000_8000);
    chk(32'(ctrl.fraction_mask), 32'h003F_FFFF);
    chk(32'({ctrl.divider_en, ctrl.pll_en, ctrl.vco_en}), 32'h7);
    chk_pin(1'b0, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_mode;
    logic [2:0] en_exp[4] = '{3'h7, 3'h6, 3'h4, 3'h7};
    for (int m = 0; m < 4; m++) begin
      wr(mk(2'(m), 1'b0, 5'h00, 4'h3, 4'h0, 4'h0, 4'h8));
      chk(32'({ctrl.divider_en, ctrl.pll_en, ctrl.vco_en}), 32'(en_exp[m]));
    end
    wr(mk(2'h0, 1'b1, 5'h00, 4'h1, 4'h0, 4'h0, 4'h8));
    chk(32'({ctrl.divider_en, ctrl.pll_en, ctrl.vco_en, powered_down}), 32'h1);
    chk(misc_feature_control, 32'h0000_8204);
    chk_pin(1'b0, 1'b0);
    // Enable low: a write must not land and outputs must freeze
    ce = 1'b0;
    wr(mk(2'h2, 1'b0, 5'h1F, 4'h3, 4'h0, 4'h0, 4'h8));
    chk(misc_feature_control, 32'h0000_8204);
    chk(32'(powered_down), 32'h1);
    ce = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(misc_feature_control, 32'h0000_8204);
    chk_pin(1'b0, 1'b0);
    $display("mode test done");
  endtask
  task automatic t_codes;
    for (int c = 0; c < 32; c++) begin
      wr(mk(2'h0, 1'b0, 5'(c), 4'h3, 4'(c), 4'(c), 4'h8));
      chk(32'(ctrl.pump_current_steps), 32'(c + 1));
      chk(32'(ctrl.filter_cap_three_pf), 32'((c % 2) + 5 * ((c % 16) / 2)));
      chk(32'(ctrl.filter_cap_four_pf), 32'(c4_pf[c % 16]));
    end
    $display("code test done");
  endtask
  task automatic t_bits;
    logic [31:0] w;
    for (int b = 0; b < 16; b++) begin
      w = mk(2'h0, 1'b0, 5'h00, 4'h3, 4'h0, 4'h0, 4'(b));
      wr(32'hA500_0000 | w);
      chk(misc_feature_control, w);
      chk(32'({ctrl.crystal_select, ctrl.detector_polarity, ctrl.reference_doubler,
        ctrl.ref_divider_bypass}), 32'({b[0], b[1], b[2], b[2]}));
      chk(32'(ctrl.fraction_mask), b[3] ? 32'h003F_FFFF : 32'h0000_03FF);
    end
    $display("bit test done");
  endtask
  task automatic t_pin;
    logic [3:0] cd[5] = '{4'h0, 4'h1, 4'h2, 4'hE, 4'hF};
    logic [1:0] pe[5] = '{2'b00, 2'b11, 2'b10, 2'b00, 2'b00};
    for (int i = 0; i < 5; i++) begin
      test_pin_select(cd[i]);
      chk_pin(pe[i][0], pe[i][1]);
    end
    test_pin_select(4'h3);
    pulses(4, 1'b1);
    chk(32'(digital_lock), 32'h0);
    chk_pin(1'b0, 1'b1);
    pulses(1, 1'b1);
    chk(32'(digital_lock), 32'h1);
    chk_pin(1'b1, 1'b1);
    test_pin_select(4'h4);
    chk_pin(1'b0, 1'b1);
    test_pin_select(4'h5);
    chk_pin(1'b0, 1'b0);
    pulses(1, 1'b0);
    chk(32'(digital_lock), 32'h0);
    chk_pin(1'b0, 1'b1);
    diag = 5'h01;
    test_pin_select(4'h6);
    chk_pin(1'b0, 1'b0);
    test_pin_select(4'h7);
    chk_pin(1'b1, 1'b1);
    // Out-of-window cycle straight into five in-window ones
    @(negedge ref_clk);
    pd_cycle = 1'b1;
    offset_in_window = 1'b0;
    pulses(5, 1'b1);
    chk(32'(digital_lock), 32'h1);
    $display("pin test done");
  endtask
  task automatic t_diag;
    logic [3:0] cd[4] = '{4'h8, 4'hA, 4'hC, 4'hD};
    logic [3:0] hv[2] = '{4'h9, 4'hB};
    logic o0;
    for (int i = 0; i < 4; i++) begin
      test_pin_select(cd[i]);
      diag_hit(5'h10 >> i, 3);
      chk_pin(1'b0, 1'b1);
      diag = 5'h10 >> i;
      repeat (2) @(negedge ref_clk);
      chk_pin(1'b1, 1'b1);
    end
    for (int i = 0; i < 2; i++) begin
      test_pin_select(hv[i]);
      o0 = pin_o;
      diag_hit(5'h10 >> i, 1);
      chk_pin(~o0, 1'b1);
      diag_hit(5'h10 >> i, 1);
      chk_pin(o0, 1'b1);
    end
    $display("diagnostic test done");
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR at %0t: run took too long", $time);
      complete_run();
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset();
    t_mode();
    t_codes();
    t_bits();
    t_pin();
    t_diag();
    complete_run();
  end
endmodule
`default_nettype wire
